// ==== sdram_mode_reg_bank.sv ====
// Device end: device information and two feature mode registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mode_params.svh"
// Notes on behaviour
// - controller writes reserved bits as zero
// - reserved bits of readable registers read zero
// - unreadable registers return junk, strobes still toggle
// - controller never writes wholly reserved registers
// - writes to read-only register change nothing
// - info bit 0 high while initialising
// - info bits 4:3 give impedance self test
// - self test updates after init calibration
// - failed self test ignores later calibration
// - info bits 6 and 7 read zero
// - burst length code 011 only
// - write recovery table without extension
// - write recovery table with extension
// - write recovery delays auto-precharge start; not modelled here, the bank only outputs writeRecoveryCycles
// - burst starts at even column, wraps eight
// - feature two bits 3:0 pick latencies
// - feature two bit 4 selects recovery table
// - only write latency set A accepted
// - read and write commands carry address
module sdram_mode_reg_bank
   import sdram_mode_pkg::*;
#(
   parameter int INIT_CYCLES = `INIT_CYCLES_DEFAULT
) (
   input wire logic clock,
   input wire logic sys_rst,
   sdram_mode_link.device link,
   input wire logic [1:0] zqPinCode,
   input wire logic [2:0] burstStartColumn,
   output logic autoInitBusy,
   output logic [2:0] burstLengthCode,
   output logic [4:0] writeRecoveryCycles,
   output logic writeRecoveryExtend,
   output logic [3:0] readLatency,
   output logic [3:0] writeLatency,
   output logic writeLatencySetSelect,
   output logic writeLeveling,
   output logic [1:0] impedanceSelftestResult,
   output logic factoryTrim,
   output logic calibrationBusy,
   output logic [23:0] burstOrder
);
   localparam int SYNC_W = 21;
   localparam int CAL_W = 16;

   logic [SYNC_W-1:0] syncFirst;
   logic [SYNC_W-1:0] syncSecond;
   logic prevLinkClk;
   logic [31:0] initCount;
   logic [CAL_W-1:0] calCount;
   logic calIsInit;
   logic [7:0] readData;
   answer_state_t answerState;
   logic [3:0] halfCount;
   logic [2:0] edgesLeft;
   logic strobe;
   logic [4:0] decodedWr;
   logic [7:0] decodedLatency;

   wire sLinkClk = syncSecond[20];
   wire sSelect = syncSecond[19];
   wire sWrite = syncSecond[18];
   wire [7:0] sAddr = syncSecond[17:10];
   wire [7:0] sOperand = syncSecond[9:2];
   wire [1:0] sZqPin = syncSecond[1:0];
   wire linkRise = sLinkClk & ~prevLinkClk;
   wire taken = linkRise & sSelect;
   wire writeTaken = taken & sWrite;
   wire readTaken = taken & ~sWrite;
   // The read-only info register has no write path at all.
   wire writeOne = writeTaken && (sAddr == `ADDR_FEATURE_ONE);
   wire writeTwo = writeTaken && (sAddr == `ADDR_FEATURE_TWO);
   wire writeCal = writeTaken && (sAddr == `ADDR_CALIBRATION);
   wire [2:0] newWrCode = sOperand[`POS_WR_CODE +: 3];
   wire burstOk = sOperand[2:0] == `BURST_CODE_BL8;
   wire [4:0] newWrCycles = wr_decode(writeRecoveryExtend, newWrCode);
   wire [7:0] newLatency = latency_decode(sOperand[3:0]);
   wire setAOnly = ~sOperand[`BIT_SET_SELECT];
   wire calCodeValid = (sOperand == `CAL_INIT) || (sOperand == `CAL_LONG) || (sOperand == `CAL_SHORT) ||
      (sOperand == `CAL_RESET);
   wire calStart = writeCal && calCodeValid && !factoryTrim && !calibrationBusy;
   wire calDone = calibrationBusy && (calCount == CAL_W'(1));
   // Reserved bits, bits 6 and 7 too, read zero.
   wire [7:0] infoValue = {3'h0, impedanceSelftestResult, 2'h0, autoInitBusy};
   // Unreadable registers answer zero, yet the strobes still run.
   wire [7:0] nextReadData = (sAddr == `ADDR_DEVICE_INFO) ? infoValue : 8'h00;
   wire halfWrap = halfCount == `STROBE_HALF_CYCLES;

   always_ff @(posedge clock) begin
      syncFirst <= {link.linkClk, link.cmdSelect, link.cmdWrite, link.modeRegAddr, link.operandBits, zqPinCode};
      syncSecond <= syncFirst;
      prevLinkClk <= sLinkClk;
   end

   // Auto-initialisation runs for a fixed time.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         initCount <= 32'h0;
         autoInitBusy <= 1'b1;
      end else if (autoInitBusy) begin
         initCount <= initCount + 32'h1;
         autoInitBusy <= (initCount + 32'h1) < 32'(INIT_CYCLES);
      end
   end

   // Feature register one: burst length and write recovery.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         burstLengthCode <= `BURST_CODE_BL8;
         decodedWr <= wr_decode(`WR_EXTEND_RESET, `WR_CODE_RESET);
      end else if (writeOne) begin
         if (burstOk) begin
            burstLengthCode <= sOperand[2:0];
         end
         if (newWrCycles != 5'h00) begin
            decodedWr <= newWrCycles;
         end
      end
   end

   // Feature register two: latencies, recovery table and leveling.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         decodedLatency <= latency_decode(`LATENCY_CODE_RESET);
         writeRecoveryExtend <= `WR_EXTEND_RESET;
         writeLatencySetSelect <= 1'b0;
         writeLeveling <= 1'b0;
      end else if (writeTwo) begin
         if (newLatency != 8'h00 && setAOnly) begin
            decodedLatency <= newLatency;
         end
         writeRecoveryExtend <= sOperand[`BIT_WR_EXTEND];
         writeLeveling <= sOperand[`BIT_WR_LEVEL];
      end
   end

   always_ff @(posedge clock) begin
      writeRecoveryCycles <= decodedWr;
      readLatency <= decodedLatency[7:4];
      writeLatency <= decodedLatency[3:0];
   end

   // Impedance calibration and its self test result.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         calibrationBusy <= 1'b0;
         calCount <= '0;
         calIsInit <= 1'b0;
         impedanceSelftestResult <= `SELFTEST_NOT_RUN;
      end else if (calStart) begin
         calibrationBusy <= 1'b1;
         calCount <= CAL_W'(`ZQ_INIT_CYCLES);
         calIsInit <= sOperand == `CAL_INIT;
      end else if (calibrationBusy) begin
         calCount <= calCount - CAL_W'(1);
         if (calDone) begin
            calibrationBusy <= 1'b0;
            if (calIsInit) begin
               impedanceSelftestResult <= sZqPin;
            end
         end
      end
   end

   // Factory trim takes over after a failed self test.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         factoryTrim <= 1'b0;
      end else begin
         factoryTrim <= (impedanceSelftestResult == `SELFTEST_TIED_HIGH) ||
            (impedanceSelftestResult == `SELFTEST_SHORTED);
      end
   end

   // Read answer: data on the bus, then a burst of strobe edges.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         answerState <= A_IDLE;
         readData <= 8'h00;
         halfCount <= 4'h0;
         edgesLeft <= 3'h0;
         strobe <= 1'b0;
      end else begin
         case (answerState)
            A_IDLE: begin
               strobe <= 1'b0;
               halfCount <= 4'h0;
               if (readTaken) begin
                  readData <= nextReadData;
                  edgesLeft <= `STROBE_EDGES;
                  answerState <= A_DRIVE;
               end
            end
            A_DRIVE: begin
               halfCount <= halfWrap ? 4'h1 : halfCount + 4'h1;
               if (halfWrap) begin
                  if (edgesLeft == 3'h0) begin
                     answerState <= A_IDLE;
                  end else begin
                     strobe <= ~strobe;
                     edgesLeft <= edgesLeft - 3'h1;
                  end
               end
            end
            default: answerState <= A_IDLE;
         endcase
      end
   end

   assign link.dqOut = readData;
   assign link.dqOe = answerState == A_DRIVE;
   assign link.dqsT = strobe;
   assign link.dqsC = ~strobe;

   // Burst address order; column bit 0 is implied zero.
   always_ff @(posedge clock) begin
      for (int i = 0; i < 8; i++) begin
         burstOrder[i*3 +: 3] <= {burstStartColumn[2:1], 1'b0} + 3'(i);
      end
   end
endmodule: sdram_mode_reg_bank
`default_nettype wire

// ==== sdram_mode_params.svh ====
// Constants shared by the mode register bank and its controller.
`ifndef SDRAM_MODE_PARAMS_SVH
`define SDRAM_MODE_PARAMS_SVH
`define CLOCK_PERIOD_NS 8
`define ADDR_DEVICE_INFO 8'h00
`define ADDR_FEATURE_ONE 8'h01
`define ADDR_FEATURE_TWO 8'h02
`define ADDR_CALIBRATION 8'h0A
`define BURST_CODE_BL8 3'h3
`define WR_CODE_RESET 3'h0
`define WR_EXTEND_RESET 1'h1
`define LATENCY_CODE_RESET 4'h8
`define MASK_FEATURE_ONE 8'hE7
`define MASK_FEATURE_TWO 8'hDF
`define BIT_INIT_BUSY 0
`define POS_SELFTEST 3
`define BIT_WR_EXTEND 4
`define BIT_SET_SELECT 6
`define BIT_WR_LEVEL 7
`define POS_WR_CODE 5
`define SELFTEST_NOT_RUN 2'h0
`define SELFTEST_TIED_HIGH 2'h1
`define SELFTEST_SHORTED 2'h2
`define CAL_INIT 8'hFF
`define CAL_LONG 8'hAB
`define CAL_SHORT 8'h56
`define CAL_RESET 8'hC3
`define ZQ_INIT_NS 1000
`define ZQ_INIT_CYCLES ((`ZQ_INIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define INIT_CYCLES_DEFAULT 200
`define STROBE_HALF_CYCLES 4'h8
`define STROBE_EDGES 3'h4
`define LINK_HALF_CYCLES 4'h4
`define READ_TIMEOUT_CYCLES 8'hFF
`define REG_TARGET 4'h0
`define REG_OPERAND 4'h1
`define REG_COMMAND 4'h2
`define REG_STATUS 4'h3
`define REG_RESULT 4'h4
`define BIT_CMD_WRITE 0
`endif

// ==== sdram_mode_pkg.sv ====
// Types and decode functions shared by both ends of the link.
`default_nettype none
package sdram_mode_pkg;
   typedef enum logic [1:0] {C_IDLE, C_ARM, C_HOLD, C_WAIT} ctrl_state_t;
   typedef enum logic {A_IDLE, A_DRIVE} answer_state_t;

   // Returns the write recovery count, or zero for a reserved code.
   function automatic logic [4:0] wr_decode(input logic extend, input logic [2:0] code);
      logic [4:0] cycles;
      cycles = 5'h00;
      if (!extend) begin
         case (code)
            3'h1: cycles = 5'h03;
            3'h4: cycles = 5'h06;
            3'h6: cycles = 5'h08;
            3'h7: cycles = 5'h09;
            default: cycles = 5'h00;
         endcase
      end else begin
         case (code)
            3'h0: cycles = 5'h0A;
            3'h1: cycles = 5'h0B;
            3'h2: cycles = 5'h0C;
            3'h4: cycles = 5'h0E;
            3'h6: cycles = 5'h10;
            default: cycles = 5'h00;
         endcase
      end
      return cycles;
   endfunction: wr_decode

   // Returns {read latency, write latency}, or zero for a reserved code.
   function automatic logic [7:0] latency_decode(input logic [3:0] code);
      logic [7:0] pair;
      pair = 8'h00;
      case (code)
         4'h4: pair = 8'h63;
         4'h6: pair = 8'h84;
         4'h7: pair = 8'h95;
         4'h8: pair = 8'hA6;
         4'h9: pair = 8'hB6;
         4'hA: pair = 8'hC6;
         4'hC: pair = 8'hE8;
         default: pair = 8'h00;
      endcase
      return pair;
   endfunction: latency_decode

   // True for an address that is wholly reserved.
   function automatic logic reserved_addr(input logic [7:0] addr);
      return (addr == 8'h09) || (addr >= 8'h0C && addr <= 8'h0F) || (addr >= 8'h12 && addr <= 8'h1F) ||
         (addr >= 8'h31 && addr <= 8'h3E) || (addr >= 8'h40);
   endfunction: reserved_addr
endpackage: sdram_mode_pkg
`default_nettype wire

// ==== sdram_mode_link.sv ====
// Command and data link between the register bank and its controller.
`timescale 1ns/1ps
`default_nettype none
interface sdram_mode_link;
   logic linkClk;
   logic cmdSelect;
   logic cmdWrite;
   logic [7:0] modeRegAddr;
   logic [7:0] operandBits;
   logic [7:0] dqOut;
   logic dqOe;
   logic dqsT;
   logic dqsC;
   logic [7:0] dq;
   // The data bus reads low when undriven.
   assign dq = dqOe ? dqOut : 8'h00;
   modport device(input linkClk, input cmdSelect, input cmdWrite, input modeRegAddr, input operandBits,
      output dqOut, output dqOe, output dqsT, output dqsC);
   modport controller(output linkClk, output cmdSelect, output cmdWrite, output modeRegAddr,
      output operandBits, input dq, input dqOe, input dqsT, input dqsC);
endinterface: sdram_mode_link
`default_nettype wire

// ==== sdram_mode_controller.sv ====
// Controller end: sends mode register commands ordered through its own registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mode_params.svh"
module sdram_mode_controller
   import sdram_mode_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   sdram_mode_link.controller link,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData
);
   ctrl_state_t state;
   logic [7:0] target;
   logic [7:0] operand;
   logic isWrite;
   logic [3:0] divCount;
   logic linkClk;
   logic [9:0] syncFirst;
   logic [9:0] syncSecond;
   logic prevStrobe;
   logic [7:0] waitCount;
   logic [7:0] result;
   logic busy;
   logic done;
   logic refused;
   logic timedOut;
   logic shadowExtend;
   logic cmdSelect;
   logic [7:0] cmdAddr;
   logic [7:0] cmdOperand;
   logic cmdWrite;

   wire divWrap = divCount == `LINK_HALF_CYCLES - 4'h1;
   wire linkFall = divWrap & linkClk;
   wire sStrobe = syncSecond[9];
   wire strobeRise = sStrobe & ~prevStrobe;
   wire goWrite = regWrite && regAddr == `REG_COMMAND && !busy;
   wire goIsWrite = regWriteData[`BIT_CMD_WRITE];
   // Reserved bits are cleared before they reach the link.
   wire [7:0] opMask = (target == `ADDR_FEATURE_ONE) ? `MASK_FEATURE_ONE :
      (target == `ADDR_FEATURE_TWO) ? `MASK_FEATURE_TWO : 8'hFF;
   wire [7:0] maskedOp = operand & opMask;
   wire badOne = target == `ADDR_FEATURE_ONE && (operand[2:0] != `BURST_CODE_BL8 ||
      wr_decode(shadowExtend, operand[`POS_WR_CODE +: 3]) == 5'h00);
   wire badTwo = target == `ADDR_FEATURE_TWO && (latency_decode(operand[3:0]) == 8'h00 ||
      operand[`BIT_SET_SELECT]);
   wire badWrite = goIsWrite && (reserved_addr(target) || badOne || badTwo);
   wire [7:0] statusValue = {4'h0, timedOut, refused, done, busy};
   wire [7:0] nextReadData = (regAddr == `REG_TARGET) ? target : (regAddr == `REG_OPERAND) ? operand :
      (regAddr == `REG_STATUS) ? statusValue : (regAddr == `REG_RESULT) ? result : 8'h00;

   // Link clock divided from the system clock.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         divCount <= 4'h0;
         linkClk <= 1'b0;
      end else begin
         divCount <= divWrap ? 4'h0 : divCount + 4'h1;
         if (divWrap) begin
            linkClk <= ~linkClk;
         end
      end
   end

   always_ff @(posedge clock) begin
      syncFirst <= {link.dqsT, link.dqOe, link.dq};
      syncSecond <= syncFirst;
      prevStrobe <= sStrobe;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         regReadData <= 8'h00;
      end else begin
         regReadData <= regRead ? nextReadData : 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         target <= 8'h00;
         operand <= 8'h00;
      end else if (regWrite && !busy) begin
         if (regAddr == `REG_TARGET) begin
            target <= regWriteData;
         end
         if (regAddr == `REG_OPERAND) begin
            operand <= regWriteData;
         end
      end
   end

   // Sequencer: launch on a link clock fall, hold one link period.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= C_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         refused <= 1'b0;
         timedOut <= 1'b0;
         isWrite <= 1'b0;
         result <= 8'h00;
         waitCount <= 8'h00;
         shadowExtend <= `WR_EXTEND_RESET;
         cmdSelect <= 1'b0;
         cmdWrite <= 1'b0;
         cmdAddr <= 8'h00;
         cmdOperand <= 8'h00;
      end else begin
         case (state)
            C_IDLE: begin
               if (goWrite) begin
                  done <= badWrite;
                  refused <= badWrite;
                  timedOut <= 1'b0;
                  isWrite <= goIsWrite;
                  busy <= !badWrite;
                  state <= badWrite ? C_IDLE : C_ARM;
               end
            end
            C_ARM: begin
               if (linkFall) begin
                  cmdSelect <= 1'b1;
                  cmdWrite <= isWrite;
                  cmdAddr <= target;
                  cmdOperand <= isWrite ? maskedOp : 8'h00;
                  state <= C_HOLD;
               end
            end
            C_HOLD: begin
               waitCount <= 8'h00;
               if (linkFall) begin
                  cmdSelect <= 1'b0;
                  if (isWrite) begin
                     if (target == `ADDR_FEATURE_TWO) begin
                        shadowExtend <= maskedOp[`BIT_WR_EXTEND];
                     end
                     busy <= 1'b0;
                     done <= 1'b1;
                     state <= C_IDLE;
                  end else begin
                     state <= C_WAIT;
                  end
               end
            end
            C_WAIT: begin
               waitCount <= waitCount + 8'h1;
               if (strobeRise) begin
                  result <= syncSecond[7:0];
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= C_IDLE;
               end else if (waitCount == `READ_TIMEOUT_CYCLES) begin
                  timedOut <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= C_IDLE;
               end
            end
            default: state <= C_IDLE;
         endcase
      end
   end

   assign link.linkClk = linkClk;
   assign link.cmdSelect = cmdSelect;
   assign link.cmdWrite = cmdWrite;
   assign link.modeRegAddr = cmdAddr;
   assign link.operandBits = cmdOperand;
endmodule: sdram_mode_controller
`default_nettype wire

// ==== sdram_mode_link_asserts.sv ====
// Concurrent checks on the link between both ends.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_link_asserts
   import sdram_mode_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic linkClk,
   input wire logic cmdSelect,
   input wire logic cmdWrite,
   input wire logic [7:0] modeRegAddr,
   input wire logic [7:0] operandBits,
   input wire logic [7:0] dqOut,
   input wire logic dqOe,
   input wire logic dqsT,
   input wire logic dqsC
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [2:0] edgeCount;
   logic lastT;
   wire logic wrOne = cmdSelect && cmdWrite && modeRegAddr == 8'h01;
   wire logic wrTwo = cmdSelect && cmdWrite && modeRegAddr == 8'h02;
   // Counts strobe edges in one answer window.
   always_ff @(posedge clock) begin
      lastT <= dqsT;
      if (sys_rst || !dqOe) begin
         edgeCount <= 3'h0;
      end else if (dqsT != lastT) begin
         edgeCount <= edgeCount + 3'h1;
      end
   end
   a_strobe_pair: assert property (dqsC == !dqsT)
      else $error("strobes not complementary");
   a_strobe_idle: assert property (!dqOe |-> !dqsT)
      else $error("strobe high outside answer");
   a_strobe_period: assert property ($changed(dqsT) |=> $stable(dqsT) [*7])
      else $error("strobe toggled early");
   a_strobe_count: assert property ($fell(dqOe) |-> edgeCount == 3'h4)
      else $error("not four strobe edges");
   a_read_answer: assert property ($rose(cmdSelect) && !cmdWrite |-> ##[1:16] dqOe)
      else $error("read not answered");
   a_answer_hold: assert property (dqOe && $past(dqOe) |-> $stable(dqOut))
      else $error("answer data moved");
   a_no_reserved: assert property (cmdSelect && cmdWrite |-> !reserved_addr(modeRegAddr))
      else $error("write to reserved register");
   a_burst_field: assert property (wrOne |-> operandBits[4:0] == 5'h03)
      else $error("bad burst or reserved bits");
   a_feature_two: assert property (wrTwo |-> operandBits[6:5] == 2'h0 && latency_decode(operandBits[3:0]) != 8'h00)
      else $error("bad feature two operand");
   a_cmd_steady: assert property (cmdSelect && !$fell(linkClk) |-> $stable(modeRegAddr) && $stable(operandBits))
      else $error("command moved mid period");
endmodule: sdram_mode_link_asserts
`default_nettype wire

// ==== tb_sdram_mode_reg_bank.sv ====
// Testbench joining both ends over the link.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mode_params.svh"
module tb_sdram_mode_reg_bank
   import sdram_mode_pkg::*;
;
   localparam int INIT = 20;
   logic clock;
   logic sys_rst;
   logic [3:0] regAddr;
   logic [7:0] regWriteData;
   logic regWrite;
   logic regRead;
   logic [7:0] regReadData;
   logic [1:0] zqPinCode;
   logic [2:0] burstStartColumn;
   logic autoInitBusy;
   logic [2:0] burstLengthCode;
   logic [4:0] writeRecoveryCycles;
   logic writeRecoveryExtend;
   logic [3:0] readLatency;
   logic [3:0] writeLatency;
   logic writeLatencySetSelect;
   logic writeLeveling;
   logic [1:0] impedanceSelftestResult;
   logic factoryTrim;
   logic calibrationBusy;
   logic [23:0] burstOrder;
   logic [7:0] st;
   logic [7:0] d;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   int strobeRises = 0;
   sdram_mode_link i_sdram_mode_link();
   sdram_mode_reg_bank #(.INIT_CYCLES(INIT)) i_sdram_mode_reg_bank(.clock(clock), .sys_rst(sys_rst),
      .link(i_sdram_mode_link), .zqPinCode(zqPinCode), .burstStartColumn(burstStartColumn),
      .autoInitBusy(autoInitBusy), .burstLengthCode(burstLengthCode), .writeRecoveryCycles(writeRecoveryCycles),
      .writeRecoveryExtend(writeRecoveryExtend), .readLatency(readLatency), .writeLatency(writeLatency),
      .writeLatencySetSelect(writeLatencySetSelect), .writeLeveling(writeLeveling),
      .impedanceSelftestResult(impedanceSelftestResult), .factoryTrim(factoryTrim),
      .calibrationBusy(calibrationBusy), .burstOrder(burstOrder));
   sdram_mode_controller i_sdram_mode_controller(.clock(clock), .sys_rst(sys_rst), .link(i_sdram_mode_link),
      .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData));
   sdram_mode_link_asserts i_sdram_mode_link_asserts(.clock(clock), .sys_rst(sys_rst),
      .linkClk(i_sdram_mode_link.linkClk), .cmdSelect(i_sdram_mode_link.cmdSelect),
      .cmdWrite(i_sdram_mode_link.cmdWrite), .modeRegAddr(i_sdram_mode_link.modeRegAddr),
      .operandBits(i_sdram_mode_link.operandBits), .dqOut(i_sdram_mode_link.dqOut),
      .dqOe(i_sdram_mode_link.dqOe), .dqsT(i_sdram_mode_link.dqsT), .dqsC(i_sdram_mode_link.dqsC));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end
   always @(posedge i_sdram_mode_link.dqsT) strobeRises++;
   task automatic give_verdict();
      if (failures == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask: give_verdict
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask: check
   task automatic do_reset(input logic [1:0] zq);
      @(posedge clock);
      sys_rst <= 1'b1;
      zqPinCode <= zq;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask: do_reset
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask: reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 d = regReadData;
   endtask: reg_rd
   // Runs one link command, polls until idle, then waits 24 cycles, past the last strobe edge of a read answer.
   task automatic run_cmd(input logic w, input logic [7:0] target, input logic [7:0] op, output logic [7:0] st);
      reg_wr(`REG_TARGET, target);
      reg_wr(`REG_OPERAND, op);
      reg_wr(`REG_COMMAND, {7'h00, w});
      st = 8'h01;
      for (int i = 0; i < 200 && st[0] !== 1'b0; i++) reg_rd(`REG_STATUS, st);
      repeat (24) @(posedge clock);
      #1;
   endtask: run_cmd
   task automatic read_mr(input logic [7:0] a, output logic [7:0] d);
      run_cmd(1'b0, a, 8'h00, st);
      check("readStatus", st, 8'h02);
      reg_rd(`REG_RESULT, d);
   endtask: read_mr
   task automatic t_defaults();
      check("initBusy", autoInitBusy, 1'b1);
      check("burst", burstLengthCode, 3'h3);
      check("recovery", writeRecoveryCycles, 5'h0A);
      check("extend", writeRecoveryExtend, 1'b1);
      check("latency", {readLatency, writeLatency}, 8'hA6);
      check("setSelect", writeLatencySetSelect, 1'b0);
      check("leveling", writeLeveling, 1'b0);
      repeat (INIT) @(posedge clock);
      #1;
      check("initDone", autoInitBusy, 1'b0);
   endtask: t_defaults
   task automatic t_info();
      read_mr(`ADDR_DEVICE_INFO, d);
      check("info", d, 8'h00);
      run_cmd(1'b1, `ADDR_DEVICE_INFO, 8'hFF, st);
      read_mr(`ADDR_DEVICE_INFO, d);
      check("infoKept", d, 8'h00);
      check("stateKept", {writeRecoveryCycles, readLatency, writeLatency}, 13'h0AA6);
   endtask: t_info
   task automatic t_unreadable();
      logic [7:0] adr [3] = '{8'h01, 8'h02, 8'h09};
      foreach (adr[i]) begin
         strobeRises = 0;
         read_mr(adr[i], d);
         check("junk", d, 8'h00);
         check("strobes", strobeRises, 24'h2);
      end
   endtask: t_unreadable
   task automatic t_recovery();
      logic [8:0] tab [9] = '{9'h10A, 9'h12B, 9'h14C, 9'h18E, 9'h1D0, 9'h023, 9'h086, 9'h0C8, 9'h0E9};
      foreach (tab[i]) begin
         run_cmd(1'b1, `ADDR_FEATURE_TWO, {3'h0, tab[i][8], 4'h8}, st);
         run_cmd(1'b1, `ADDR_FEATURE_ONE, {tab[i][7:5], 5'h03}, st);
         check("recovery", writeRecoveryCycles, tab[i][4:0]);
         check("extend", writeRecoveryExtend, tab[i][8]);
      end
   endtask: t_recovery
   task automatic t_latency();
      logic [11:0] tab [7] = '{12'h463, 12'h684, 12'h795, 12'h8A6, 12'h9B6, 12'hAC6, 12'hCE8};
      foreach (tab[i]) begin
         run_cmd(1'b1, `ADDR_FEATURE_TWO, {i[0], 3'h1, tab[i][11:8]}, st);
         check("latency", {readLatency, writeLatency}, tab[i][7:0]);
         check("leveling", writeLeveling, i[0]);
         check("setSelect", writeLatencySetSelect, 1'b0);
      end
   endtask: t_latency
   task automatic t_refuse();
      logic [15:0] bad [5] = '{16'h0900, 16'h0102, 16'h0163, 16'h0248, 16'h0213};
      foreach (bad[i]) begin
         run_cmd(1'b1, bad[i][15:8], bad[i][7:0], st);
         check("refused", st[2], 1'b1);
         check("kept", {writeRecoveryCycles, burstLengthCode, readLatency, writeLatency}, 16'h4BE8);
      end
   endtask: t_refuse
   task automatic t_burst();
      logic [2:0] s [6] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h3, 3'h7};
      logic [23:0] exp;
      foreach (s[i]) begin
         @(posedge clock);
         burstStartColumn <= s[i];
         repeat (3) @(posedge clock);
         #1;
         for (int k = 0; k < 8; k++) exp[3 * k +: 3] = (s[i] & 3'h6) + k[2:0];
         check("order", burstOrder, exp);
      end
   endtask: t_burst
   // A failed self test locks calibration out, so each pin state gets a fresh reset.
   task automatic t_cal();
      logic [1:0] zq [3] = '{2'h3, 2'h1, 2'h2};
      foreach (zq[i]) begin
         do_reset(zq[i]);
         repeat (INIT) @(posedge clock);
         run_cmd(1'b1, `ADDR_CALIBRATION, `CAL_INIT, st);
         check("calRunning", {calibrationBusy, impedanceSelftestResult}, 3'h4);
         for (int k = 0; k < 300 && calibrationBusy !== 1'b0; k++) @(posedge clock);
         repeat (2) @(posedge clock);
         #1;
         check("selftest", impedanceSelftestResult, zq[i]);
         check("trim", factoryTrim, zq[i] != 2'h3);
         read_mr(`ADDR_DEVICE_INFO, d);
         check("info", d, {3'h0, zq[i], 3'h0});
         if (zq[i] != 2'h3) begin
            @(posedge clock);
            zqPinCode <= 2'h3;
            run_cmd(1'b1, `ADDR_CALIBRATION, `CAL_INIT, st);
            check("calIgnored", {calibrationBusy, impedanceSelftestResult}, {1'b0, zq[i]});
         end
      end
   endtask: t_cal
   initial begin
      sys_rst = 1'b1;
      regAddr = 4'h0;
      regWriteData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      zqPinCode = 2'h0;
      burstStartColumn = 3'h0;
      do_reset(2'h0);
      t_defaults();
      t_info();
      t_unreadable();
      t_recovery();
      t_latency();
      t_refuse();
      t_burst();
      t_cal();
      give_verdict();
   end
endmodule: tb_sdram_mode_reg_bank
`default_nettype wire
